/* core/gpib_pkg.sv */
// constants and carrier types for the instrument bus port
package gpib_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_NS      = 8;
  localparam int SETTLE_NS   = 2000;
  localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 9;

  // ************************************************************
  // command codes on seven data lines
  // ************************************************************
  localparam logic [6:0] C_GTL   = 7'h01;
  localparam logic [6:0] C_SDC   = 7'h04;
  localparam logic [6:0] C_PPC   = 7'h05;
  localparam logic [6:0] C_GET   = 7'h08;
  localparam logic [6:0] C_LLO   = 7'h11;
  localparam logic [6:0] C_DCL   = 7'h14;
  localparam logic [6:0] C_PPU   = 7'h15;
  localparam logic [6:0] C_SPE   = 7'h18;
  localparam logic [6:0] C_SPD   = 7'h19;
  localparam logic [6:0] C_UNL   = 7'h3F;
  localparam logic [6:0] C_UNT   = 7'h5F;
  localparam logic [6:0] C_LAG   = 7'h20;
  localparam logic [6:0] C_TAG   = 7'h40;
  localparam logic [6:0] C_PPE_LO = 7'h60;
  localparam logic [6:0] C_PPE_HI = 7'h6F;
  localparam logic [6:0] C_PPD   = 7'h70;
  localparam logic [3:0] PPCFG_RST = 4'h0;

  // ************************************************************
  // carrier types
  // ************************************************************
  // pin levels or pull-low enables, one bit per bus line
  typedef struct packed {
    logic [7:0] dio;
    logic       atn;
    logic       eoi;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic       ifc;
    logic       ren;
    logic       srq;
  } bus_t;

  // decoded interface message
  typedef struct packed {
    logic       my_listen;
    logic       my_talk;
    logic       unl;
    logic       unt;
    logic       other_talk;
    logic       addressed;
    logic       universal;
    logic       sdc;
    logic       get;
    logic       ppc;
    logic       dcl;
    logic       ppu;
    logic       spe;
    logic       spd;
    logic       ppe;
    logic       ppd;
    logic [3:0] ppe_bits;
  } cmd_t;

  typedef enum logic [1:0] {
    AH_WAIT  = 2'b00,
    AH_READY = 2'b01,
    AH_TAKE  = 2'b10
  } ah_t;

  typedef enum logic [1:0] {
    SH_IDLE   = 2'b00,
    SH_SETTLE = 2'b01,
    SH_VALID  = 2'b10,
    SH_DONE   = 2'b11
  } sh_t;

endpackage

/* core/gpib_cmd_decode.sv */
// decoder from a command byte to interface message flags
`timescale 1ns/1ps
`default_nettype none

module gpib_cmd_decode (
  // command byte, lines one to seven
  input  wire logic [6:0]     code,
  // own primary address
  input  wire logic [4:0]     my_addr,
  // decoded message
  output var gpib_pkg::cmd_t  cmd
);

  // ************************************************************
  // address groups and command groups
  // ************************************************************
  always_comb
  begin
    cmd            = '0;
    cmd.unl        = (code == gpib_pkg::C_UNL);
    cmd.unt        = (code == gpib_pkg::C_UNT);
    // address thirty-one is the unaddress code, never our own
    cmd.my_listen  = (code == (gpib_pkg::C_LAG | {2'b00, my_addr})) && !cmd.unl;
    cmd.my_talk    = (code == (gpib_pkg::C_TAG | {2'b00, my_addr})) && !cmd.unt;
    cmd.other_talk = (code[6:5] == 2'b10) && !cmd.my_talk && !cmd.unt;
    // addressed group 0x00..0x0F, universal group 0x10..0x1F
    cmd.addressed  = (code[6:4] == 3'b000);
    cmd.universal  = (code[6:4] == 3'b001);
    cmd.sdc        = (code == gpib_pkg::C_SDC);
    cmd.get        = (code == gpib_pkg::C_GET);
    cmd.ppc        = (code == gpib_pkg::C_PPC);
    cmd.dcl        = (code == gpib_pkg::C_DCL);
    cmd.ppu        = (code == gpib_pkg::C_PPU);
    cmd.spe        = (code == gpib_pkg::C_SPE);
    cmd.spd        = (code == gpib_pkg::C_SPD);
    // sixteen enable codes, one disable code
    cmd.ppe        = (code >= gpib_pkg::C_PPE_LO) && (code <= gpib_pkg::C_PPE_HI);
    cmd.ppd        = (code == gpib_pkg::C_PPD);
    cmd.ppe_bits   = code[3:0];
  end

endmodule

`default_nettype wire

/* core/gpib_port.sv */
// instrument side of a general purpose instrument bus port
`timescale 1ns/1ps
`default_nettype none

module gpib_port (
  // clock, reset, enable
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire logic           ce,
  // bus pins: level in, constant low out, pull-low enable
  input  wire gpib_pkg::bus_t pin_in,
  output var gpib_pkg::bus_t  pin_out,
  output var gpib_pkg::bus_t  pin_oe_n,
  // configuration
  input  wire logic [4:0]     my_addr,
  input  wire logic           talk_only,
  input  wire logic           listen_only,
  // received device data
  output logic [7:0]          rx_data,
  output logic                rx_eoi,
  output logic                rx_valid,
  input  wire logic           rx_ready,
  // device data to send
  input  wire logic [7:0]     tx_data,
  input  wire logic           tx_eoi,
  input  wire logic           tx_valid,
  output logic                tx_ready,
  // device status and events
  input  wire logic [7:0]     status_byte,
  input  wire logic           ist,
  input  wire logic           srq_req,
  output logic                dev_clear,
  output logic                dev_trigger,
  output logic                remote,
  output logic                listen,
  output logic                talk
);

  // ************************************************************
  // bus levels to true flags
  // ************************************************************
  logic       atn;
  logic       eoi;
  logic       dav;
  logic       nrfd_t;
  logic       ndac_t;
  logic       ifc;
  logic [7:0] dio_t;
  gpib_pkg::cmd_t cmd;

  // each line is inverted on its own
  assign atn    = !pin_in.atn;
  assign eoi    = !pin_in.eoi;
  assign dav    = !pin_in.dav;
  assign nrfd_t = !pin_in.nrfd;
  assign ndac_t = !pin_in.ndac;
  assign ifc    = !pin_in.ifc;
  assign dio_t  = ~pin_in.dio;

  // lines one to seven carry the command code
  gpib_cmd_decode u_dec (
    .code    (dio_t[6:0]),
    .my_addr (my_addr),
    .cmd     (cmd)
  );

  // ************************************************************
  // acceptor handshake and role state
  // ************************************************************
  gpib_pkg::ah_t ah_r, ah_nxt;
  logic       lad_r, lad_nxt;
  logic       tad_r, tad_nxt;
  logic       spe_r, spe_nxt;
  logic       ppc_r, ppc_nxt;
  logic [3:0] ppcfg_r, ppcfg_nxt;
  logic       ppen_r, ppen_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic       rxe_r, rxe_nxt;
  logic       rxv_r, rxv_nxt;
  logic       clr_r, clr_nxt;
  logic       trg_r, trg_nxt;
  logic       is_listener;
  logic       is_talker;
  logic       ah_active;
  logic       ah_hold;

  // data moves only when addressed or in only-mode
  assign is_listener = lad_r || listen_only;
  assign is_talker   = tad_r || talk_only;
  // commands always taken, data only by a listener
  assign ah_active   = atn || is_listener;
  // unread byte keeps ready-for-data pulled while ATN is released
  assign ah_hold     = !atn && rxv_r && !rx_ready;

  // handshake, decode and role bookkeeping; no controller built
  always_comb
  begin
    ah_nxt    = ah_r;
    lad_nxt   = lad_r;
    tad_nxt   = tad_r;
    spe_nxt   = spe_r;
    ppc_nxt   = ppc_r;
    ppcfg_nxt = ppcfg_r;
    ppen_nxt  = ppen_r;
    rxd_nxt   = rxd_r;
    rxe_nxt   = rxe_r;
    rxv_nxt   = rxv_r && !rx_ready;
    clr_nxt   = 1'b0;
    trg_nxt   = 1'b0;
    unique case (ah_r)
      gpib_pkg::AH_WAIT:
      begin
        if (ah_active && !ah_hold && !dav)
          ah_nxt = gpib_pkg::AH_READY;
      end
      gpib_pkg::AH_READY:
      begin
        if (!ah_active || ah_hold)
          ah_nxt = gpib_pkg::AH_WAIT;
        else if (dav)
        begin
          ah_nxt = gpib_pkg::AH_TAKE;
          if (atn)
          begin
            // command byte
            if (cmd.my_listen)
              lad_nxt = 1'b1;
            if (cmd.unl)
              lad_nxt = 1'b0;
            if (cmd.my_talk)
              tad_nxt = 1'b1;
            if (cmd.unt || cmd.other_talk)
              tad_nxt = 1'b0;
            // universal group regardless of addressing
            if (cmd.dcl)
              clr_nxt = 1'b1;
            if (cmd.ppu)
              ppen_nxt = 1'b0;
            if (cmd.spe)
              spe_nxt = 1'b1;
            if (cmd.spd)
              spe_nxt = 1'b0;
            // addressed group only while listen-addressed
            if (cmd.addressed && lad_r)
            begin
              if (cmd.sdc)
                clr_nxt = 1'b1;
              if (cmd.get)
                trg_nxt = 1'b1;
              ppc_nxt = cmd.ppc;
            end
            else if (cmd.addressed || cmd.universal)
              ppc_nxt = 1'b0;
            // secondary after configure: enable or disable
            if (ppc_r && cmd.ppe)
            begin
              ppcfg_nxt = cmd.ppe_bits;
              ppen_nxt  = 1'b1;
            end
            if (ppc_r && cmd.ppd)
              ppen_nxt = 1'b0;
          end
          else
          begin
            // device data, eight bits
            rxd_nxt = dio_t;
            rxe_nxt = eoi;
            rxv_nxt = 1'b1;
          end
        end
      end
      gpib_pkg::AH_TAKE:
      begin
        if (!dav)
          ah_nxt = gpib_pkg::AH_WAIT;
      end
      default:
        ah_nxt = gpib_pkg::AH_WAIT;
    endcase
    // interface clear drops every address
    if (ifc)
    begin
      lad_nxt = 1'b0;
      tad_nxt = 1'b0;
      spe_nxt = 1'b0;
      ppc_nxt = 1'b0;
    end
  end

  // acceptor and role registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ah_r    <= gpib_pkg::AH_WAIT;
      lad_r   <= 1'b0;
      tad_r   <= 1'b0;
      spe_r   <= 1'b0;
      ppc_r   <= 1'b0;
      ppcfg_r <= gpib_pkg::PPCFG_RST;
      ppen_r  <= 1'b0;
      rxd_r   <= 8'h00;
      rxe_r   <= 1'b0;
      rxv_r   <= 1'b0;
      clr_r   <= 1'b0;
      trg_r   <= 1'b0;
    end
    else if (ce)
    begin
      ah_r    <= ah_nxt;
      lad_r   <= lad_nxt;
      tad_r   <= tad_nxt;
      spe_r   <= spe_nxt;
      ppc_r   <= ppc_nxt;
      ppcfg_r <= ppcfg_nxt;
      ppen_r  <= ppen_nxt;
      rxd_r   <= rxd_nxt;
      rxe_r   <= rxe_nxt;
      rxv_r   <= rxv_nxt;
      clr_r   <= clr_nxt;
      trg_r   <= trg_nxt;
    end
  end

  // ************************************************************
  // source handshake
  // ************************************************************
  localparam int CNT_W = gpib_pkg::CNT_W;
  localparam logic [CNT_W-1:0] SETTLE = CNT_W'(gpib_pkg::SETTLE_CYC);
  gpib_pkg::sh_t sh_r, sh_nxt;
  logic [7:0]       txd_r, txd_nxt;
  logic             txe_r, txe_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             sh_go;

  // talker sends only with ATN released
  assign sh_go    = is_talker && !atn;
  assign tx_ready = sh_go && !spe_r && (sh_r == gpib_pkg::SH_IDLE);

  // one byte held until every acceptor took it
  always_comb
  begin
    sh_nxt  = sh_r;
    txd_nxt = txd_r;
    txe_nxt = txe_r;
    cnt_nxt = cnt_r;
    unique case (sh_r)
      gpib_pkg::SH_IDLE:
      begin
        if (sh_go && (spe_r || tx_valid))
        begin
          txd_nxt = spe_r ? status_byte : tx_data;
          txe_nxt = spe_r ? 1'b0 : tx_eoi;
          cnt_nxt = SETTLE;
          sh_nxt  = gpib_pkg::SH_SETTLE;
        end
      end
      gpib_pkg::SH_SETTLE:
      begin
        if (cnt_r != '0)
          cnt_nxt = cnt_r - CNT_W'(1);
        else if (!nrfd_t)
          sh_nxt = gpib_pkg::SH_VALID;
      end
      gpib_pkg::SH_VALID:
      begin
        if (!ndac_t)
          sh_nxt = gpib_pkg::SH_DONE;
      end
      gpib_pkg::SH_DONE:
      begin
        if (ndac_t || spe_r)
          sh_nxt = spe_r ? gpib_pkg::SH_DONE : gpib_pkg::SH_IDLE;
      end
    endcase
    // controller takes the bus back: drop the byte
    if (!sh_go && sh_r != gpib_pkg::SH_DONE)
      sh_nxt = gpib_pkg::SH_IDLE;
    if (!sh_go && sh_r == gpib_pkg::SH_DONE)
      sh_nxt = gpib_pkg::SH_IDLE;
  end

  // source registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sh_r  <= gpib_pkg::SH_IDLE;
      txd_r <= 8'h00;
      txe_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (ce)
    begin
      sh_r  <= sh_nxt;
      txd_r <= txd_nxt;
      txe_r <= txe_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ************************************************************
  // pin drive, pull low or release only
  // ************************************************************
  logic       ppoll;
  logic [7:0] pp_line;
  logic       sh_drv;

  // poll answer while EOI and ATN asserted
  assign ppoll   = ppen_r && atn && eoi;
  assign pp_line = (ist == ppcfg_r[3]) ? (8'h01 << ppcfg_r[2:0]) : 8'h00;
  assign sh_drv  = sh_go && (sh_r != gpib_pkg::SH_IDLE);

  // output level is always low; release is the only high
  assign pin_out = '0;

  // pull-low enables, active low
  always_comb
  begin
    pin_oe_n      = '1;
    pin_oe_n.dio  = ~((sh_drv ? txd_r : 8'h00) | (ppoll ? pp_line : 8'h00));
    pin_oe_n.eoi  = !(sh_drv && txe_r);
    pin_oe_n.dav  = !(sh_drv && (sh_r == gpib_pkg::SH_VALID));
    pin_oe_n.nrfd = !(ah_active && ah_r != gpib_pkg::AH_READY);
    pin_oe_n.ndac = !(ah_active && ah_r != gpib_pkg::AH_TAKE);
    pin_oe_n.srq  = !srq_req;
  end

  // user-side outputs
  assign rx_data     = rxd_r;
  assign rx_eoi      = rxe_r;
  assign rx_valid    = rxv_r;
  assign dev_clear   = clr_r;
  assign dev_trigger = trg_r;
  assign remote      = !pin_in.ren;
  assign listen      = is_listener;
  assign talk        = is_talker;

endmodule

`default_nettype wire

/* verification/gpib_port_checker.sv */
// assertion checker for the instrument bus port
`timescale 1ns/1ps
`default_nettype none

module gpib_port_checker (
  // clock and reset
  input wire logic           clk,
  input wire logic           nrst,
  // bus pins
  input wire gpib_pkg::bus_t pin_in,
  input wire gpib_pkg::bus_t pin_out,
  input wire gpib_pkg::bus_t pin_oe_n,
  // user side
  input wire logic [7:0]     rx_data,
  input wire logic           rx_valid,
  input wire logic           rx_ready,
  input wire logic           tx_ready,
  input wire logic           srq_req,
  input wire logic           dev_clear,
  input wire logic           dev_trigger,
  input wire logic           remote,
  input wire logic           listen
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_out_low: assert property (pin_out == '0)
    else $error("pin level not low");
  chk_srq_pull: assert property (pin_oe_n.srq == !srq_req)
    else $error("srq pull wrong");
  chk_ren_remote: assert property (remote == !pin_in.ren)
    else $error("remote not ren");
  chk_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx byte lost");
  chk_rx_take: assert property ($rose(rx_valid) |-> $past(pin_in.atn) && $past(listen))
    else $error("rx byte wrongly taken");
  chk_trig_listen: assert property (dev_trigger |-> $past(listen))
    else $error("trigger not listening");
  chk_pulse_atn: assert property (dev_clear || dev_trigger |-> !$past(pin_in.atn))
    else $error("command without atn");
  chk_dav_rfd: assert property ($fell(pin_oe_n.dav) |-> $past(pin_in.nrfd))
    else $error("dav before ready");
  chk_dio_hold: assert property (!pin_oe_n.dav && !$past(pin_oe_n.dav) |-> $stable(pin_oe_n.dio))
    else $error("dio moved under dav");
  chk_tx_gate: assert property (!pin_in.atn |-> !tx_ready)
    else $error("tx ready under atn");
  chk_idle_lines: assert property (pin_in.atn && !listen
    && $past(pin_in.atn) && !$past(listen) |-> pin_oe_n.nrfd && pin_oe_n.ndac)
    else $error("handshake held unaddressed");

  // main scenarios
  cov_listen: cover property ($rose(listen));
  cov_trigger: cover property (dev_trigger);
  cov_source: cover property ($fell(pin_oe_n.dav));
  cov_poll: cover property (!pin_in.eoi && !pin_in.atn && pin_oe_n.dio != 8'hFF);
endmodule

bind gpib_port gpib_port_checker i_chk (
  .clk(clk), .nrst(nrst), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_ready(tx_ready),
  .srq_req(srq_req), .dev_clear(dev_clear), .dev_trigger(dev_trigger),
  .remote(remote), .listen(listen)
);
`default_nettype wire

/* verification/gpib_ctl_model.sv */
// model of the controller in charge on the far side of the bus
`timescale 1ns/1ps
`default_nettype none

module gpib_ctl_model (
  // clock
  input  wire logic           clk,
  // device pull-low enables in, wired bus levels out
  input  wire gpib_pkg::bus_t dut_oe_n,
  output var gpib_pkg::bus_t  lvl
);
  // ************************************************************
  // wired bus
  // ************************************************************
  gpib_pkg::bus_t pull;
  int             stalls = 0;

  // pulled by any party reads low, else pull-up high
  assign lvl = gpib_pkg::bus_t'(dut_oe_n & ~pull);
  initial pull = '0; // system controller, in charge from time zero

  // one bounded wait step
  task automatic tick(inout int n);
    @(negedge clk);
    n++;
  endtask

  // one multi-line byte, command or data by atn
  task automatic send(input logic atn, input logic [7:0] b, input logic e);
    int n;
    n = 0;
    @(negedge clk);
    pull.atn = atn;
    pull.dio = b;
    pull.eoi = e;
    tick(n);
    while (lvl.nrfd !== 1'b1 && n < 1000) tick(n);
    pull.dav = 1'b1;
    tick(n);
    while (lvl.ndac !== 1'b1 && n < 1000) tick(n);
    pull.dav = 1'b0;
    pull.dio = '0;
    pull.eoi = 1'b0;
    if (n >= 1000) stalls++;
    tick(n);
  endtask

  // accept one byte from the device talker
  task automatic recv(output logic [7:0] b, output logic e);
    int n;
    n = 0;
    @(negedge clk);
    pull.ndac = 1'b1;
    while (lvl.dav !== 1'b0 && n < 1000) tick(n);
    b = ~lvl.dio;
    e = ~lvl.eoi;
    pull.nrfd = 1'b1;
    pull.ndac = 1'b0;
    while (lvl.dav !== 1'b1 && n < 1000) tick(n);
    pull.ndac = 1'b1;
    tick(n);
    tick(n);
    pull.nrfd = 1'b0;
    pull.ndac = 1'b0;
    if (n >= 1000) stalls++;
  endtask

  // parallel poll: eoi with atn, read the answer lines
  task automatic poll(output logic [7:0] r);
    @(negedge clk);
    pull.atn = 1'b1;
    pull.eoi = 1'b1;
    @(negedge clk);
    r = ~lvl.dio;
    pull.eoi = 1'b0;
  endtask

  // uni-line controls
  task automatic set_atn(input logic a);
    @(negedge clk);
    pull.atn = a;
  endtask
  task automatic set_ren(input logic r);
    pull.ren = r;
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking testbench for the instrument bus port
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ************************************************************
  // signals
  // ************************************************************
  localparam logic [6:0] ADDR = 7'h05;
  logic           clk = 1'b0;
  logic           nrst, rx_ready, tx_eoi, tx_valid, ist, srq_req, ce, talk_only, listen_only;
  logic [7:0]     tx_data, rx_data, status_byte;
  logic           rx_eoi, rx_valid, tx_ready, dev_clear, dev_trigger, remote, listen, talk;
  gpib_pkg::bus_t lvl, oe_n, pout;
  int             mismatches = 0, checks_done = 0, cyc = 0, n_clr = 0, n_trg = 0;
  logic [7:0]     rxq[$];

  gpib_port i_dut (
    .clk(clk), .nrst(nrst), .ce(ce), .pin_in(lvl), .pin_out(pout), .pin_oe_n(oe_n),
    .my_addr(ADDR[4:0]), .talk_only(talk_only), .listen_only(listen_only),
    .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .status_byte(status_byte), .ist(ist), .srq_req(srq_req), .dev_clear(dev_clear),
    .dev_trigger(dev_trigger), .remote(remote), .listen(listen), .talk(talk)
  );
  gpib_ctl_model i_ctl (.clk(clk), .dut_oe_n(oe_n), .lvl(lvl));

  // clock, event counters, hang limit
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (dev_clear === 1'b1) n_clr++;
    if (dev_trigger === 1'b1) n_trg++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task finish_test;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task cmd(input logic [6:0] c);
    i_ctl.send(1'b1, {1'b0, c}, 1'b0);
  endtask
  task put(input logic [7:0] d, input logic e);
    int n;
    n = 0;
    @(negedge clk);
    tx_data = d;
    tx_eoi = e;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // data and addressed commands ignored, universal obeyed
  task t_unaddressed;
    i_ctl.send(1'b0, 8'h33, 1'b0);
    cmd(gpib_pkg::C_GET);
    cmd(gpib_pkg::C_SDC);
    cmd(gpib_pkg::C_DCL);
    check("rx count", 8'(rxq.size()), 8'h00);
    check("trigger", 8'(n_trg), 8'h00);
    check("clear", 8'(n_clr), 8'h01);
  endtask
  // listen addressed: commands act, data bytes received
  task t_listen;
    cmd(gpib_pkg::C_LAG | ADDR);
    check("listen", listen, 1'b1);
    cmd(gpib_pkg::C_GET);
    cmd(gpib_pkg::C_SDC);
    check("trigger", 8'(n_trg), 8'h01);
    check("clear", 8'(n_clr), 8'h02);
    rx_ready = 1'b0;
    i_ctl.send(1'b0, 8'h81, 1'b0);
    repeat (3) @(negedge clk);
    check("rx held", rx_valid, 1'b1);
    rx_ready = 1'b1;
    i_ctl.send(1'b0, 8'h7E, 1'b1);
    repeat (2) @(negedge clk);
    check("rx first", rxq.pop_front(), 8'h81);
    check("rx second", rxq.pop_front(), 8'h7E);
    check("rx end", rx_eoi, 1'b1);
  endtask
  // parallel poll enable codes 0x68 and top end 0x6F, then disable
  task t_ppoll;
    logic [7:0] r;
    cmd(gpib_pkg::C_PPC);
    cmd(7'h68);
    ist = 1'b1;
    i_ctl.poll(r);
    check("poll line1", r, 8'h01);
    cmd(gpib_pkg::C_PPC);
    cmd(7'h6F);
    ist = 1'b0;
    i_ctl.poll(r);
    check("poll sense", r, 8'h00);
    ist = 1'b1;
    i_ctl.poll(r);
    check("poll line8", r, 8'h80);
    cmd(gpib_pkg::C_PPC);
    cmd(7'h70);
    i_ctl.poll(r);
    check("poll off", r, 8'h00);
  endtask
  // talk addressed: one byte with end mark to the controller
  task t_talk;
    logic [7:0] b;
    logic       e;
    cmd(gpib_pkg::C_UNL);
    check("unlisten", listen, 1'b0);
    cmd(gpib_pkg::C_TAG | ADDR);
    check("talk", talk, 1'b1);
    i_ctl.set_atn(1'b0);
    fork
      put(8'hA5, 1'b1);
      i_ctl.recv(b, e);
    join
    check("tx byte", b, 8'hA5);
    check("tx end", e, 1'b1);
    cmd(gpib_pkg::C_UNT);
    check("untalk", talk, 1'b0);
  endtask
  // serial poll: status byte sent instead of user data
  task t_spoll;
    logic [7:0] b;
    logic       e;
    status_byte = 8'h42;
    cmd(gpib_pkg::C_TAG | ADDR);
    cmd(gpib_pkg::C_SPE);
    i_ctl.set_atn(1'b0);
    i_ctl.recv(b, e);
    check("spoll byte", b, 8'h42);
    check("spoll end", e, 1'b0);
    cmd(gpib_pkg::C_SPD);
    cmd(gpib_pkg::C_UNT);
    check("spoll untalk", talk, 1'b0);
  endtask
  // only-modes, then mid-run reset with clock enable low
  task t_modes;
    @(negedge clk);
    listen_only = 1'b1;
    talk_only = 1'b1;
    @(negedge clk);
    check("listen only", listen, 1'b1);
    check("talk only", talk, 1'b1);
    listen_only = 1'b0;
    talk_only = 1'b0;
    @(negedge clk);
    ce = 1'b0;
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check("frozen rfd", lvl.nrfd, 1'b0);
    ce = 1'b1;
    @(negedge clk);
    check("ready rfd", lvl.nrfd, 1'b1);
    check("reset listen", listen, 1'b0);
  endtask
  // two uni-line messages at once, each on its own
  task t_uni;
    @(negedge clk);
    srq_req = 1'b1;
    i_ctl.set_ren(1'b1);
    @(negedge clk);
    check("srq low", lvl.srq, 1'b0);
    check("remote", remote, 1'b1);
    srq_req = 1'b0;
    @(negedge clk);
    check("srq free", lvl.srq, 1'b1);
    check("remote held", remote, 1'b1);
    i_ctl.set_ren(1'b0);
  endtask

  // main sequence
  initial
  begin
    nrst = 1'b0;
    rx_ready = 1'b1;
    tx_data = 8'h00;
    tx_eoi = 1'b0;
    tx_valid = 1'b0;
    ist = 1'b0;
    srq_req = 1'b0;
    ce = 1'b1;
    talk_only = 1'b0;
    listen_only = 1'b0;
    status_byte = 8'h00;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_unaddressed();
    t_listen();
    t_ppoll();
    t_talk();
    t_spoll();
    t_uni();
    t_modes();
    check("stalls", 8'(i_ctl.stalls), 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
